// ### hw/ppc_pkg.sv
// Purpose: constants and types for the parallel port control block
// Assumes: 32-bit register port, one control register
// Notes: field positions follow the control word layout
package ppc_pkg;
	localparam logic [3:0] CONTROL_OFFSET = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;
	localparam int ENABLE_BIT = 15;
	localparam int STOP_IDLE_BIT = 13;
	localparam int MUX_HI_BIT = 12;
	localparam int MUX_LO_BIT = 11;
	localparam int BUFFER_LEVEL_BIT = 10;
	localparam int WRITE_PIN_EN_BIT = 9;
	localparam int READ_PIN_EN_BIT = 8;
	localparam int SELECT_FN_HI_BIT = 7;
	localparam int SELECT_FN_LO_BIT = 6;
	localparam int LATCH_POL_BIT = 5;
	localparam int SELECT_ONE_POL_BIT = 3;
	localparam int WRITE_POL_BIT = 1;
	localparam int READ_POL_BIT = 0;
	localparam logic [15:0] CONTROL_WRITE_MASK = 16'hBFEB;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;

	typedef enum logic [1:0] {
		MUX_NONE = 2'h0,
		MUX_LOW_BYTE = 2'h1,
		MUX_ALL_ON_BYTE = 2'h2,
		MUX_ALL_ON_WORD = 2'h3
	} mux_mode_type;

	typedef enum logic [1:0] {
		SEL_BOTH_ADDRESS = 2'h0,
		SEL_TWO_CHIP = 2'h1,
		SEL_BOTH_CHIP = 2'h2,
		SEL_RESERVED = 2'h3
	} select_fn_type;

	typedef struct packed {
		logic [15:0] address;
		logic [15:0] data;
		logic select_one;
		logic select_two;
		logic write_strobe;
		logic read_strobe;
		logic latch_low;
		logic latch_high;
	} pin_request_type;

	typedef struct packed {
		logic [15:0] data_out;
		logic [15:0] data_oe;
		logic [15:0] address_out;
		logic [15:0] address_oe;
		logic select_one_out;
		logic select_two_out;
		logic write_strobe_out;
		logic write_strobe_oe;
		logic read_strobe_out;
		logic read_strobe_oe;
		logic latch_low_out;
		logic latch_high_out;
	} pin_drive_type;
endpackage : ppc_pkg

// ### hw/parallel_port_control_config.sv
// Purpose: control register and pin steering of the parallel master port
// Assumes: one 20 MHz clock; strobe sequencing comes from elsewhere
// Notes: request holds the cycle's address, data and logical strobes
//
// Operation
// - With enable set the port drives pins; cleared, no off-chip access.
// - With stop_in_idle set the port halts while the device is idle.
// - Mux 11 puts 16 address bits on data 15:0; mux 10 on data 7:0.
// - Mux 01 puts address 7:0 on data 7:0 and 15:8 on address pins.
// - Mux 00 keeps address and data on separate pins.
// - The write strobe pin enable lets the port drive that pin.
// - The read strobe pin enable lets the port drive that pin.
// - Select function 10 makes both select pins chip selects; 11 reserved.
// - Select function 01: select two is chip select, select one is A14.
// - Select function 00: select two carries A15, select one A14.
// - Latch polarity set makes both latch strobes high-active, else low.
// - Select function and polarity do nothing on pins used as address.
// - Unimplemented control bits, including bits 31:16, read as zero.
`timescale 1ns/1ps
module parallel_port_control_config (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [3:0] address,
	input wire logic [31:0] write_data,
	input wire logic write_strobe,
	input wire logic read_strobe,
	output logic [31:0] read_data,
	input wire logic device_idle,
	input wire ppc_pkg::pin_request_type request,
	output ppc_pkg::pin_drive_type pins,
	output logic port_active,
	output logic input_buffer_level_select
);
	import ppc_pkg::*;

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic reset_sync1_reg;
	logic reset_sync2_reg;
	logic rst_n;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			reset_sync1_reg <= 1'b0;
			reset_sync2_reg <= 1'b0;
		end else begin
			reset_sync1_reg <= 1'b1;
			reset_sync2_reg <= reset_sync1_reg;
		end
	end
	assign rst_n = reset_sync2_reg;

	// ------------------------------------------------------------
	// Idle input synchroniser
	// ------------------------------------------------------------
	// Idle comes from the power manager, treated as foreign
	logic idle_sync1_reg;
	logic idle_sync2_reg;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			idle_sync1_reg <= 1'b0;
			idle_sync2_reg <= 1'b0;
		end else begin
			idle_sync1_reg <= device_idle;
			idle_sync2_reg <= idle_sync1_reg;
		end
	end

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	logic [15:0] control_reg;
	logic [15:0] control_next;
	logic [31:0] read_data_reg;
	logic [31:0] read_data_next;

	function automatic logic [31:0] read_mux(
		input logic [3:0] addr,
		input logic [15:0] ctrl,
		input logic act
	);
		logic [31:0] value;
		value = 32'h0000_0000;
		case (addr)
			CONTROL_OFFSET: value = {16'h0000, ctrl};
			STATUS_OFFSET: value = {31'h0000_0000, act};
			default: value = 32'h0000_0000;
		endcase
		return value;
	endfunction : read_mux

	always_comb begin
		control_next = control_reg;
		if (write_strobe && address == CONTROL_OFFSET) begin
			// Unimplemented bits never store, so they read zero
			control_next = write_data[15:0] & CONTROL_WRITE_MASK;
		end
		read_data_next = 32'h0000_0000;
		if (read_strobe) begin
			read_data_next = read_mux(address, control_reg, port_active);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			control_reg <= CONTROL_RESET;
			read_data_reg <= 32'h0000_0000;
		end else begin
			control_reg <= control_next;
			read_data_reg <= read_data_next;
		end
	end
	assign read_data = read_data_reg;

	// ------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------
	mux_mode_type mux_mode;
	select_fn_type select_fn;
	logic latch_active_high;
	logic select_one_active_high;
	logic write_active_high;
	logic read_active_high;
	logic write_pin_enable;
	logic read_pin_enable;

	assign mux_mode = mux_mode_type'(control_reg[MUX_HI_BIT:MUX_LO_BIT]);
	assign select_fn =
		select_fn_type'(control_reg[SELECT_FN_HI_BIT:SELECT_FN_LO_BIT]);
	assign latch_active_high = control_reg[LATCH_POL_BIT];
	assign select_one_active_high = control_reg[SELECT_ONE_POL_BIT];
	assign write_active_high = control_reg[WRITE_POL_BIT];
	assign read_active_high = control_reg[READ_POL_BIT];
	assign write_pin_enable = control_reg[WRITE_PIN_EN_BIT];
	assign read_pin_enable = control_reg[READ_PIN_EN_BIT];
	assign input_buffer_level_select = control_reg[BUFFER_LEVEL_BIT];
	// Register access after clearing enable is safe here

	always_comb begin
		port_active = control_reg[ENABLE_BIT];
		if (control_reg[STOP_IDLE_BIT] && idle_sync2_reg) begin
			port_active = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Pin helpers
	// ------------------------------------------------------------
	// Logical assertion to pin level for one polarity bit
	function automatic logic apply_polarity(
		input logic level,
		input logic active_high
	);
		logic pin_level;
		pin_level = active_high ? level : ~level;
		return pin_level;
	endfunction : apply_polarity

	// Address pins only where no data pin carries that part
	function automatic logic [15:0] address_enables(
		input mux_mode_type mode
	);
		logic [15:0] enables;
		enables = 16'h0000;
		case (mode)
			MUX_NONE: enables = 16'hFFFF;
			MUX_LOW_BYTE: enables = 16'hFF00;
			MUX_ALL_ON_BYTE: enables = 16'h0000;
			MUX_ALL_ON_WORD: enables = 16'h0000;
			default: enables = 16'h0000;
		endcase
		return enables;
	endfunction : address_enables

	// ------------------------------------------------------------
	// Data and latch steering
	// ------------------------------------------------------------
	logic [15:0] data_value;
	logic latch_low_level;
	logic latch_high_level;

	always_comb begin
		data_value = request.data;
		latch_low_level = 1'b0;
		latch_high_level = 1'b0;
		case (mux_mode)
			MUX_ALL_ON_WORD: begin
				if (request.latch_low) begin
					data_value = request.address;
				end
				latch_low_level = request.latch_low;
			end
			MUX_ALL_ON_BYTE: begin
				// Byte-wide bus: low then high address half
				if (request.latch_low) begin
					data_value[7:0] = request.address[7:0];
				end else if (request.latch_high) begin
					data_value[7:0] = request.address[15:8];
				end
				latch_low_level = request.latch_low;
				latch_high_level = request.latch_high;
			end
			MUX_LOW_BYTE: begin
				if (request.latch_low) begin
					data_value[7:0] = request.address[7:0];
				end
				latch_low_level = request.latch_low;
			end
			MUX_NONE: begin
				data_value = request.data;
			end
			default: begin
				data_value = request.data;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Select pin steering
	// ------------------------------------------------------------
	logic select_one_value;
	logic select_two_value;

	always_comb begin
		select_one_value = request.address[14];
		select_two_value = request.address[15];
		case (select_fn)
			SEL_BOTH_CHIP: begin
				select_two_value = request.select_two;
				// Polarity only where select one is a chip select
				select_one_value = apply_polarity(request.select_one,
					select_one_active_high);
			end
			SEL_TWO_CHIP: begin
				select_two_value = request.select_two;
				select_one_value = request.address[14];
			end
			SEL_BOTH_ADDRESS: begin
				select_two_value = request.address[15];
				select_one_value = request.address[14];
			end
			default: begin
				// Reserved code: pins carry address, safest choice
				select_two_value = request.address[15];
				select_one_value = request.address[14];
			end
		endcase
	end

	// ------------------------------------------------------------
	// Strobe pin steering
	// ------------------------------------------------------------
	logic write_pin_level;
	logic read_pin_level;

	always_comb begin
		write_pin_level = 1'b0;
		read_pin_level = 1'b0;
		// Disabled strobe pin is released and held low inside
		if (write_pin_enable) begin
			write_pin_level = apply_polarity(request.write_strobe,
				write_active_high);
		end
		if (read_pin_enable) begin
			read_pin_level = apply_polarity(request.read_strobe,
				read_active_high);
		end
	end

	// ------------------------------------------------------------
	// Pin register
	// ------------------------------------------------------------
	pin_drive_type drive_next;
	pin_drive_type drive_reg;

	always_comb begin
		drive_next = '0;
		// Disabled port leaves every pin and enable low except the two latch strobes
		if (port_active) begin
			drive_next.data_out = data_value;
			drive_next.data_oe = 16'hFFFF;
			drive_next.address_out = request.address;
			drive_next.address_oe = address_enables(mux_mode);
			drive_next.select_one_out = select_one_value;
			drive_next.select_two_out = select_two_value;
			drive_next.write_strobe_oe = write_pin_enable;
			drive_next.write_strobe_out = write_pin_level;
			drive_next.read_strobe_oe = read_pin_enable;
			drive_next.read_strobe_out = read_pin_level;
		end
		// Latches show their inactive level while disabled; reset holds them low
		drive_next.latch_low_out = apply_polarity(
			latch_low_level & port_active, latch_active_high);
		drive_next.latch_high_out = apply_polarity(
			latch_high_level & port_active, latch_active_high);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			drive_reg <= '0;
		end else begin
			drive_reg <= drive_next;
		end
	end
	assign pins = drive_reg;
endmodule : parallel_port_control_config

// ### verification/ppc_monitor.sv
// Purpose: port checker for the parallel port control block
// Assumes: a control write lands on the edge of its strobe
// Notes: keeps a shadow of the control word
`timescale 1ns/1ps
module ppc_monitor (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [3:0] address,
	input wire logic [31:0] write_data,
	input wire logic write_strobe,
	input wire logic read_strobe,
	input wire logic [31:0] read_data,
	input wire logic device_idle,
	input wire ppc_pkg::pin_request_type request,
	input wire ppc_pkg::pin_drive_type pins,
	input wire logic port_active
);
	import ppc_pkg::*;
	logic [15:0] ctrl_reg;
	logic [15:0] ctrl_next;
	always_comb begin
		ctrl_next = ctrl_reg;
		if (write_strobe && address == CONTROL_OFFSET)
			ctrl_next = write_data[15:0] & CONTROL_WRITE_MASK;
	end
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			ctrl_reg <= CONTROL_RESET;
		else
			ctrl_reg <= ctrl_next;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	read_idle_a: assert property (!$past(read_strobe) |-> !read_data)
		else $error("read data outside a read");
	ctrl_read_a: assert property ($past(read_strobe) &&
		$past(address) == CONTROL_OFFSET |-> read_data == {16'h0, $past(ctrl_reg)})
		else $error("control read back");
	spare_zero_a: assert property (!(read_data & 32'hFFFF4014))
		else $error("unused bit set");
	enable_off_a: assert property (!ctrl_reg[ENABLE_BIT] |-> !port_active)
		else $error("active while off");
	idle_stop_a: assert property (ctrl_reg[ENABLE_BIT] |-> port_active ==
		!(ctrl_reg[STOP_IDLE_BIT] && $past(device_idle, 2)))
		else $error("idle stop");
	pins_off_a: assert property (!$past(port_active) |-> !pins.address_oe
		&& !pins.data_oe && !pins.write_strobe_oe && !pins.read_strobe_oe)
		else $error("pins driven while off");
	strobe_oe_a: assert property ({pins.write_strobe_oe, pins.read_strobe_oe}
		== ({2{$past(port_active)}} & $past(ctrl_reg[9:8])))
		else $error("strobe enable");
	addr_oe_a: assert property ($past(port_active) |-> pins.address_oe ==
		($past(ctrl_reg[12:11]) == 2'h0 ? 16'hFFFF :
		$past(ctrl_reg[12:11]) == 2'h1 ? 16'hFF00 : 16'h0))
		else $error("address enables");
	latch_pol_a: assert property ($past(port_active) &&
		$past(ctrl_reg[MUX_HI_BIT:MUX_LO_BIT]) != 2'h0 |->
		pins.latch_low_out ==
		($past(request.latch_low) ~^ $past(ctrl_reg[LATCH_POL_BIT])))
		else $error("latch polarity");
	sel_addr_a: assert property ($past(ctrl_reg[7:6]) != 2'h2 &&
		$past(port_active) |-> pins.select_one_out == $past(request.address[14]))
		else $error("select one as address");
	cover property ($past(port_active) && pins.write_strobe_oe);
	cover property (ctrl_reg[STOP_IDLE_BIT] && !port_active);
	cover property ($past(read_strobe) && read_data != 32'h0);
endmodule : ppc_monitor
bind parallel_port_control_config ppc_monitor i_ppc_monitor (
	.clock(clock), .arst_n(arst_n), .address(address),
	.write_data(write_data), .write_strobe(write_strobe),
	.read_strobe(read_strobe), .read_data(read_data),
	.device_idle(device_idle), .request(request), .pins(pins),
	.port_active(port_active));

// ### verification/ppc_partner.sv
// Purpose: far-side device that takes data on the write strobe
// Assumes: strobe level given by active_high
// Notes: keeps only the last word
`timescale 1ns/1ps
module ppc_partner (
	input wire logic clock,
	input wire ppc_pkg::pin_drive_type pins,
	input wire logic active_high,
	output logic [15:0] last_data
);
	initial last_data = 16'h0;
	always @(posedge clock) begin
		if (pins.write_strobe_oe && pins.write_strobe_out == active_high)
			last_data <= pins.data_out;
	end
endmodule : ppc_partner

// ### verification/parallel_port_control_config_tb.sv
// Purpose: self-checking bench for the parallel port control block
// Assumes: read data stands only in the cycle after the strobe
// Notes: pin steering is also watched by the bound checker
`timescale 1ns/1ps
module parallel_port_control_config_tb;
	import ppc_pkg::*;
	logic clock, arst_n, write_strobe, read_strobe, device_idle, port_active;
	logic [3:0] address;
	logic [31:0] write_data, read_data;
	logic [15:0] last_data;
	pin_request_type request;
	pin_drive_type pins;
	int n_errors = 0, num_checks = 0, cycles = 0;
	localparam logic [15:0] OE_EXP [4] = '{16'hFFFF, 16'hFF00, 16'h0, 16'h0};
	parallel_port_control_config i_parallel_port_control_config (
		.clock(clock), .arst_n(arst_n), .address(address),
		.write_data(write_data), .write_strobe(write_strobe),
		.read_strobe(read_strobe), .read_data(read_data),
		.device_idle(device_idle), .request(request), .pins(pins),
		.port_active(port_active), .input_buffer_level_select());
	ppc_partner i_ppc_partner (.clock(clock), .pins(pins),
		.active_high(1'b1), .last_data(last_data));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			n_errors++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %0h vs %0h", $time, seen, exp);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		write_strobe <= 1'b1;
		address <= a;
		write_data <= d;
		@(posedge clock);
		write_strobe <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clock);
		read_strobe <= 1'b1;
		address <= a;
		@(posedge clock);
		read_strobe <= 1'b0;
		#1 check(read_data, exp);
	endtask : rd
	initial begin
		arst_n = 1'b0;
		write_strobe = 1'b0;
		read_strobe = 1'b0;
		address = 4'h0;
		write_data = 32'h0;
		device_idle = 1'b0;
		request = '0;
		repeat (6) @(posedge clock);
		arst_n <= 1'b1;
		step(3);
		rd(CONTROL_OFFSET, 32'h0);
		rd(4'h8, 32'h0);
		wr(CONTROL_OFFSET, 32'hFFFFFFFF);
		rd(CONTROL_OFFSET, 32'h0000BFEB);
		$display("test registers done");
		wr(CONTROL_OFFSET, 32'h0000A000);
		step(0);
		check(32'(port_active), 32'h1);
		@(posedge clock);
		device_idle <= 1'b1;
		step(3);
		rd(4'h4, 32'h0);
		wr(CONTROL_OFFSET, 32'h00008000);
		rd(4'h4, 32'h1);
		wr(CONTROL_OFFSET, 32'h0000A000);
		@(posedge clock);
		device_idle <= 1'b0;
		step(3);
		rd(4'h4, 32'h1);
		$display("test idle done");
		for (int m = 0; m < 4; m++) begin
			wr(CONTROL_OFFSET, 32'h8220 | 32'(m << 11));
			request.address <= 16'h5AC3;
			request.latch_low <= 1'b1;
			step(2);
			check(32'(pins.address_oe), 32'(OE_EXP[m]));
			check(32'({pins.write_strobe_oe, pins.read_strobe_oe}), 32'h2);
			if (m == 2)
				check(32'(pins.data_out[7:0]), 32'hC3);
			if (m == 3)
				check(32'(pins.data_out), 32'h5AC3);
			check(32'(pins.latch_low_out), 32'(m != 0));
		end
		wr(CONTROL_OFFSET, 32'h00009220);
		request.latch_low <= 1'b0;
		request.latch_high <= 1'b1;
		step(2);
		check(32'(pins.data_out[7:0]), 32'h5A);
		check(32'(pins.latch_high_out), 32'h1);
		for (int f = 0; f < 3; f++) begin
			wr(CONTROL_OFFSET, 32'h8000 | 32'(f << 6));
			request.select_one <= 1'b1;
			request.select_two <= 1'b1;
			step(2);
			check(32'(pins.select_one_out), 32'(f != 2));
			check(32'(pins.select_two_out), 32'(f != 0));
		end
		$display("test pins done");
		wr(CONTROL_OFFSET, 32'h00008302);
		request.data <= 16'hC35A;
		request.write_strobe <= 1'b1;
		step(2);
		check(32'(last_data), 32'hC35A);
		check(32'(pins.read_strobe_oe), 32'h1);
		check(32'(pins.read_strobe_out), 32'h1);
		wr(CONTROL_OFFSET, 32'h0);
		// Quiet cycles after disabling
		step(2);
		check(32'(pins.address_oe), 32'h0);
		check(32'(pins.data_oe), 32'h0);
		check(32'(pins.latch_low_out), 32'h1);
		$display("test partner done");
		final_report();
	end
endmodule : parallel_port_control_config_tb
